// file: core/cal_ctrl_cfg.svh
// Register map, field positions and reset values of the calibration control bank.
// Assumes inclusion by bare name from core/ sources only.
`ifndef CAL_CTRL_CFG_SVH
`define CAL_CTRL_CFG_SVH
`define ADDR_OFFSET_AVERAGING_CONTROL 7'h68
`define ADDR_CALIBRATION_STATUS_FLAGS 7'h6A
`define ADDR_STATUS_PIN_TRIGGER_SELECT 7'h6B
`define ADDR_SOFTWARE_TRIGGER_LEVEL 7'h6C
`define ADDR_LOW_POWER_BACKGROUND_CONFIG 7'h6E
`define ADDR_CAL_RUN_CONFIG 7'h62
`define RST_OFFSET_AVERAGING_CONTROL 8'h61
`define RST_STATUS_PIN_TRIGGER_SELECT 8'h00
`define RST_SOFTWARE_TRIGGER_LEVEL 8'h01
`define RST_LOW_POWER_BACKGROUND_CONFIG 8'h88
`define RST_CAL_RUN_CONFIG 8'h01
`define AVG_DEPTH_HI 6
`define AVG_DEPTH_LO 4
`define AVG_FIXED_VALUE 4'h1
`define STAT_CODE_HI 4
`define STAT_CODE_LO 2
`define STAT_STOPPED_BIT 1
`define STAT_FG_COMPLETE_BIT 0
`define PIN_SEL_HI 2
`define PIN_SEL_LO 1
`define PIN_TRIG_SRC_BIT 0
`define SOFT_TRIG_BIT 0
`define LP_WAKE_MODE_BIT 1
`define LP_EN_BIT 0
`define RUN_FG_BIT 0
`define RUN_BG_BIT 1
`define SPI_ADDR_BITS 7
`endif

// file: core/cal_ctrl_pkg.sv
// Types shared by the calibration control bank modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package cal_ctrl_pkg;
    typedef enum logic [1:0] {
        PIN_FG_COMPLETE,
        PIN_BG_STOPPED,
        PIN_ALARM,
        PIN_LOW
    } pin_sel_t;
    typedef logic [7:0] reg_byte_t;
endpackage : cal_ctrl_pkg
`default_nettype wire

// file: core/cal_trig_if.sv
// Carries selected trigger and its sources between bank and trigger selector.
// Assumes both ends on clk_sys.
`default_nettype none
interface cal_trig_if;
    logic src_hw;
    logic soft_level;
    logic pin_level;
    logic trig_level;
    modport bank (output src_hw, output soft_level, output pin_level, input trig_level);
    modport sel (input src_hw, input soft_level, input pin_level, output trig_level);
endinterface : cal_trig_if
`default_nettype wire

// file: core/cal_trig_select.sv
// Trigger source multiplexer, registered.
// Assumes pin level arrives already synchronised.
`default_nettype none
module cal_trig_select (
    input wire logic clk_sys,   // system clock
    input wire logic rst_n,     // sync reset, active low
    input wire logic clk_en,    // freezes state when low
    cal_trig_if.sel trig        // trigger sources and result
);
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            trig.trig_level <= 1'b1;
        end else if (clk_en) begin
            trig.trig_level <= trig.src_hw ? trig.pin_level : trig.soft_level;
        end
    end
endmodule : cal_trig_select
`default_nettype wire

// file: core/calibration_control_status.sv
// Calibration control and status register bank with serial register port.
// Assumes an SPI-style port: active-low chip select, mode 0, 16-bit frames
// (read bit, 7-bit address, 8 data bits), pins asynchronous to clk_sys.
// Notes on behaviour
// - Averaging depth bits 6-4; low nibble fixed 1.
// - Status register read-only; code in bits 4-2.
// - Set stopped flag when background halts.
// - Clear stopped flag when calibration resumes.
// - Without background, stopped follows foreground done.
// - Foreground done flag in bit 0.
// - Selector bits 2-1 choose status pin source.
// - Source bit 0 uses software trigger only.
// - Source bit 1 uses hardware pin only.
// - Software trigger bit resets to one.
// - Low-power register resets to 0x88.
// - Foreground control runs or skips foreground.
// - Trigger-driven low power wakes on low trigger.
`default_nettype none
`include "cal_ctrl_cfg.svh"
module calibration_control_status
    import cal_ctrl_pkg::*;
#(
    parameter int ADDR_BITS = `SPI_ADDR_BITS
) (
    input wire logic clk_sys,            // 20 MHz system clock
    input wire logic rst_n,              // sync reset, active low
    input wire logic clk_en,             // freezes all state when low
    input wire logic spi_cs_n,           // register port select, active low
    input wire logic spi_sclk,           // register port clock (sampled)
    input wire logic spi_sdi,            // register port data in
    output logic spi_sdo,                // register port data out
    output logic spi_sdo_oe,             // high while driving spi_sdo
    input wire logic trigger_input_pin,  // hardware calibration trigger
    input wire logic alarm,              // alarm level from device
    input wire logic fg_complete,        // foreground completed, pulse
    input wire logic bg_halted,          // background stopped at phase, pulse
    input wire logic cal_resumed,        // calibration operating again, pulse
    input wire logic cal_restart,        // calibration values reset, pulse
    input wire logic [2:0] cal_code,     // calibration status code
    output logic status_output_pin,      // selected status level
    output logic [2:0] offset_average_depth, // averaging depth to engine
    output logic foreground_run_enable,  // run foreground on restart
    output logic background_run_enable,  // background calibration on
    output logic [7:0] low_power_cfg,    // low-power settings to engine
    output logic cal_trigger,            // selected trigger level
    output logic core_wake               // wake sleeping core
);
    // Frame layout and decoder are built for a 7-bit address only
    if (ADDR_BITS != 7) begin : g_addr_bits_check
        $error("ADDR_BITS must be 7");
    end

    reg_byte_t offset_averaging_control;
    reg_byte_t status_pin_trigger_select;
    reg_byte_t software_trigger_level;
    reg_byte_t low_power_background_config;
    reg_byte_t cal_run_config;
    logic foreground_complete_flag;
    logic bg_stopped_flag;
    logic [2:0] status_code;

    // Two-flop synchronisers on all pins
    logic [1:0] cs_sync, sclk_sync, sdi_sync, trig_sync;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cs_sync <= 2'h3;
            sclk_sync <= 2'h0;
            sdi_sync <= 2'h0;
            trig_sync <= 2'h3;
        end else if (clk_en) begin
            cs_sync <= {cs_sync[0], spi_cs_n};
            sclk_sync <= {sclk_sync[0], spi_sclk};
            sdi_sync <= {sdi_sync[0], spi_sdi};
            trig_sync <= {trig_sync[0], trigger_input_pin};
        end
    end

    logic sclk_prev;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sclk_prev <= 1'b0;
        end else if (clk_en) begin
            sclk_prev <= sclk_sync[1];
        end
    end
    logic active, rise, fall;
    assign active = !cs_sync[1];
    assign rise = active && sclk_sync[1] && !sclk_prev;
    assign fall = active && !sclk_sync[1] && sclk_prev;

    // Frame shifter: bit count, header, data
    logic [4:0] bit_cnt;
    logic [15:0] shift_in;
    logic [7:0] shift_out;
    logic wr_stb;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bit_cnt <= 5'h00;
            shift_in <= 16'h0000;
        end else if (clk_en) begin
            if (!active) begin
                bit_cnt <= 5'h00;
            end else if (rise && bit_cnt != 5'h10) begin
                bit_cnt <= bit_cnt + 5'h01;
                shift_in <= {shift_in[14:0], sdi_sync[1]};
            end
        end
    end
    assign wr_stb = clk_en && rise && bit_cnt == 5'h0F && !shift_in[14];

    function automatic reg_byte_t read_mux(input logic [6:0] a);
        reg_byte_t d;
        d = 8'h00;
        if (a == `ADDR_OFFSET_AVERAGING_CONTROL) begin
            d = offset_averaging_control;
        end else if (a == `ADDR_CALIBRATION_STATUS_FLAGS) begin
            d = {3'h0, status_code, bg_stopped_flag, foreground_complete_flag};
        end else if (a == `ADDR_STATUS_PIN_TRIGGER_SELECT) begin
            d = status_pin_trigger_select;
        end else if (a == `ADDR_SOFTWARE_TRIGGER_LEVEL) begin
            d = software_trigger_level;
        end else if (a == `ADDR_LOW_POWER_BACKGROUND_CONFIG) begin
            d = low_power_background_config;
        end else if (a == `ADDR_CAL_RUN_CONFIG) begin
            d = cal_run_config;
        end
        return d;
    endfunction : read_mux

    // Read data loaded as the last address bit (frame bit 8) arrives, shifted on falling edges
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            shift_out <= 8'h00;
        end else if (clk_en) begin
            if (rise && bit_cnt == 5'h07) begin
                shift_out <= read_mux({shift_in[5:0], sdi_sync[1]});
            end else if (fall && bit_cnt >= 5'h09) begin
                shift_out <= {shift_out[6:0], 1'b0};
            end
        end
    end
    // Read flag latched on the first bit; it moves up the shifter later
    logic is_read;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            is_read <= 1'b0;
        end else if (clk_en) begin
            if (rise && bit_cnt == 5'h00) begin
                is_read <= sdi_sync[1];
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            spi_sdo <= 1'b0;
            spi_sdo_oe <= 1'b0;
        end else if (clk_en) begin
            spi_sdo <= shift_out[7];
            spi_sdo_oe <= active && bit_cnt >= 5'h08 && is_read;
        end
    end

    logic [6:0] wr_addr;
    reg_byte_t wr_data;
    assign wr_addr = shift_in[13:7];
    assign wr_data = {shift_in[6:0], sdi_sync[1]};

    // Writable registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            offset_averaging_control <= `RST_OFFSET_AVERAGING_CONTROL;
            status_pin_trigger_select <= `RST_STATUS_PIN_TRIGGER_SELECT;
            software_trigger_level <= `RST_SOFTWARE_TRIGGER_LEVEL;
            low_power_background_config <= `RST_LOW_POWER_BACKGROUND_CONFIG;
            cal_run_config <= `RST_CAL_RUN_CONFIG;
        end else if (wr_stb) begin
            if (wr_addr == `ADDR_OFFSET_AVERAGING_CONTROL) begin
                offset_averaging_control <= {wr_data[7:4], `AVG_FIXED_VALUE};
            end else if (wr_addr == `ADDR_STATUS_PIN_TRIGGER_SELECT) begin
                status_pin_trigger_select <= wr_data;
            end else if (wr_addr == `ADDR_SOFTWARE_TRIGGER_LEVEL) begin
                software_trigger_level <= wr_data;
            end else if (wr_addr == `ADDR_LOW_POWER_BACKGROUND_CONFIG) begin
                low_power_background_config <= wr_data;
            end else if (wr_addr == `ADDR_CAL_RUN_CONFIG) begin
                cal_run_config <= wr_data;
            end
        end
    end

    // Status flags; events win over the restart clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            foreground_complete_flag <= 1'b0;
            bg_stopped_flag <= 1'b0;
            status_code <= 3'h0;
        end else if (clk_en) begin
            status_code <= cal_code;
            if (fg_complete || (cal_restart && !foreground_run_enable)) begin
                foreground_complete_flag <= 1'b1;
            end else if (cal_restart) begin
                foreground_complete_flag <= 1'b0;
            end
            if (bg_halted || (!background_run_enable &&
                    (fg_complete || (cal_restart && !foreground_run_enable)))) begin
                bg_stopped_flag <= 1'b1;
            end else if (cal_resumed || cal_restart) begin
                bg_stopped_flag <= 1'b0;
            end
        end
    end

    cal_trig_if trig_bus ();
    assign trig_bus.src_hw = status_pin_trigger_select[`PIN_TRIG_SRC_BIT];
    assign trig_bus.soft_level = software_trigger_level[`SOFT_TRIG_BIT];
    assign trig_bus.pin_level = trig_sync[1];
    cal_trig_select u_trig (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .trig(trig_bus)
    );

    pin_sel_t pin_sel;
    assign pin_sel = pin_sel_t'(status_pin_trigger_select[`PIN_SEL_HI:`PIN_SEL_LO]);
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            status_output_pin <= 1'b0;
            core_wake <= 1'b0;
        end else if (clk_en) begin
            case (pin_sel)
                PIN_FG_COMPLETE: status_output_pin <= foreground_complete_flag;
                PIN_BG_STOPPED: status_output_pin <= bg_stopped_flag;
                PIN_ALARM: status_output_pin <= alarm;
                default: status_output_pin <= 1'b0;
            endcase
            core_wake <= low_power_background_config[`LP_EN_BIT] &&
                low_power_background_config[`LP_WAKE_MODE_BIT] && !trig_bus.trig_level;
        end
    end

    assign offset_average_depth = offset_averaging_control[`AVG_DEPTH_HI:`AVG_DEPTH_LO];
    assign foreground_run_enable = cal_run_config[`RUN_FG_BIT];
    assign background_run_enable = cal_run_config[`RUN_BG_BIT];
    assign low_power_cfg = low_power_background_config;
    assign cal_trigger = trig_bus.trig_level;
endmodule : calibration_control_status
`default_nettype wire

// file: verif/cal_ctrl_monitor.sv
// Port-level checks of the calibration control and status bank.
// Assumes one clock domain and a bind from the bench top file.
`default_nettype none
module cal_ctrl_monitor (
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset, active low
    input wire logic spi_cs_n, // port select
    input wire logic spi_sdo_oe, // read drive enable
    input wire logic trigger_input_pin, // hardware trigger
    input wire logic status_output_pin, // status pin
    input wire logic [2:0] offset_average_depth, // averaging depth
    input wire logic foreground_run_enable, // run foreground
    input wire logic background_run_enable, // run background
    input wire logic [7:0] low_power_cfg, // low-power settings
    input wire logic cal_trigger, // selected trigger
    input wire logic core_wake // core wake
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_rst_out;
        $rose(rst_n) |-> cal_trigger && !core_wake && !status_output_pin && !spi_sdo_oe;
    endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("outputs not at reset levels");
    property p_rst_regs;
        $rose(rst_n) |-> offset_average_depth == 3'h6 && low_power_cfg == 8'h88
            && foreground_run_enable && !background_run_enable;
    endproperty
    a_rst_regs: assert property (p_rst_regs)
        else $error("register outputs not at reset values");
    property p_oe_idle;
        spi_cs_n [*6] |-> !spi_sdo_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("read data driven outside a frame");
    // Settings only move through register frames
    property p_cfg_hold;
        spi_cs_n [*8] |=> $stable({offset_average_depth, low_power_cfg,
            foreground_run_enable, background_run_enable});
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("settings changed without a frame");
    property p_wake_off;
        (low_power_cfg[1:0] != 2'b11) [*3] |-> !core_wake;
    endproperty
    a_wake_off: assert property (p_wake_off)
        else $error("core woken outside trigger mode");
    property p_wake_on;
        (low_power_cfg[1:0] == 2'b11 && !cal_trigger) [*3] |-> core_wake;
    endproperty
    a_wake_on: assert property (p_wake_on)
        else $error("core not woken by low trigger");
    property p_wake_cfg;
        core_wake && $stable(low_power_cfg) |-> low_power_cfg[1:0] == 2'b11;
    endproperty
    a_wake_cfg: assert property (p_wake_cfg)
        else $error("wake without trigger mode");
    property p_trig_hold;
        (spi_cs_n && $stable(trigger_input_pin)) [*6] |-> $stable(cal_trigger);
    endproperty
    a_trig_hold: assert property (p_trig_hold)
        else $error("trigger moved with quiet sources");
endmodule : cal_ctrl_monitor
`default_nettype wire

// file: verif/spi_host_model.sv
// Host on the serial register port: mode 0 frames, sclk idle low.
// Assumes the bench calls xfer only after reset has been released.
`default_nettype none
module spi_host_model (
    input wire logic clk_sys, // system clock
    output logic spi_cs_n, // select, active low
    output logic spi_sclk, // serial clock
    output logic spi_sdi, // data to device
    input wire logic spi_sdo // data from device
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi = 1'b0;
    end
    // Six-cycle phases leave margin over the two-flop sampler
    task automatic xfer(input logic [15:0] frame, output logic [7:0] q);
        @(negedge clk_sys);
        spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_sdi = frame[i];
            repeat (6) @(negedge clk_sys);
            spi_sclk = 1'b1;
            if (i < 8) q[i] = spi_sdo;
            repeat (6) @(negedge clk_sys);
            spi_sclk = 1'b0;
        end
        repeat (6) @(negedge clk_sys);
        spi_cs_n = 1'b1;
        spi_sdi = ~spi_sdi;
        repeat (6) @(negedge clk_sys);
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// file: verif/calibration_control_status_test.sv
// Self-checking bench for the calibration control and status bank.
// Assumes design, host model and checker compiled before this file.
`default_nettype none
module calibration_control_status_test;
    import cal_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst_n, clk_en, trigger_input_pin, alarm, spi_cs_n, spi_sclk, spi_sdi;
    logic [3:0] pin_exp = 4'b0101;
    logic spi_sdo, spi_sdo_oe, status_output_pin, foreground_run_enable;
    logic background_run_enable, cal_trigger, core_wake;
    logic [3:0] ev;
    logic [2:0] cal_code, offset_average_depth;
    reg_byte_t low_power_cfg, rd;
    int n_mismatch = 0;
    int compares = 0;
    // Rows: {read flag and address, write data, expected read}
    logic [23:0] rows [11] = '{24'hE8_00_61, 24'hEA_00_00, 24'hEB_00_00, 24'hEC_00_01,
        24'hEE_00_88, 24'h68_71_00, 24'hE8_00_71, 24'h6A_FF_00, 24'hEA_00_00,
        24'h10_FF_00, 24'h90_00_00};
    calibration_control_status calibration_control_status_i (.clk_sys(clk_sys),
        .rst_n(rst_n), .clk_en(clk_en), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
        .trigger_input_pin(trigger_input_pin), .alarm(alarm), .fg_complete(ev[0]),
        .bg_halted(ev[1]), .cal_resumed(ev[2]), .cal_restart(ev[3]), .cal_code(cal_code),
        .status_output_pin(status_output_pin), .offset_average_depth(offset_average_depth),
        .foreground_run_enable(foreground_run_enable),
        .background_run_enable(background_run_enable), .low_power_cfg(low_power_cfg),
        .cal_trigger(cal_trigger), .core_wake(core_wake));
    spi_host_model spi_host_model_i (.clk_sys(clk_sys), .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));
    task automatic tally_and_finish;
        if (n_mismatch == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // Drive enable looked at deep in the data phase of each frame
    task automatic xfer_chk(input logic [15:0] f, input logic oe_exp);
        fork
            spi_host_model_i.xfer(f, rd);
            begin
                repeat (150) @(negedge clk_sys);
                check(spi_sdo_oe, oe_exp);
            end
        join
    endtask : xfer_chk
    task automatic wr(input logic [6:0] a, input reg_byte_t d);
        xfer_chk({1'b0, a, d}, 1'b0);
    endtask : wr
    task automatic rd_chk(input logic [6:0] a, input reg_byte_t e);
        xfer_chk({1'b1, a, 8'h00}, 1'b1);
        check(rd, e);
    endtask : rd_chk
    task automatic pulse(input int k);
        ev[k] = 1'b1;
        @(negedge clk_sys);
        ev = 4'h0;
        repeat (3) @(negedge clk_sys);
    endtask : pulse
    task automatic pin_chk(input logic p, input logic t, input logic w);
        trigger_input_pin = p;
        repeat (6) @(negedge clk_sys);
        check(cal_trigger, t);
        check(core_wake, w);
    endtask : pin_chk
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(negedge clk_sys);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        {rst_n, trigger_input_pin, alarm, ev, cal_code} = '0;
        clk_en = 1'b1;
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        for (int i = 0; i < 11; i++) begin
            if (rows[i][23]) rd_chk(rows[i][22:16], rows[i][7:0]);
            else wr(rows[i][22:16], rows[i][15:8]);
        end
        check(offset_average_depth, 3'h7);
        cal_code = 3'h5;
        pulse(3);
        rd_chk(7'h6A, 8'h14);
        pulse(0);
        rd_chk(7'h6A, 8'h17);
        pulse(2);
        rd_chk(7'h6A, 8'h15);
        alarm = 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(7'h6B, {5'h00, 2'(k), 1'b0});
            check(status_output_pin, pin_exp[k]);
        end
        wr(7'h6B, {5'h00, PIN_ALARM, 1'b0});
        alarm = 1'b0;
        repeat (3) @(negedge clk_sys);
        check(status_output_pin, 1'b0);
        pulse(1);
        rd_chk(7'h6A, 8'h17);
        pulse(3);
        rd_chk(7'h6A, 8'h14);
        wr(7'h62, 8'h00);
        check(foreground_run_enable, 1'b0);
        pulse(2);
        pulse(3);
        rd_chk(7'h6A, 8'h17);
        wr(7'h6E, 8'h03);
        wr(7'h6C, 8'h00);
        pin_chk(1'b1, 1'b0, 1'b1);
        wr(7'h6B, 8'h01);
        pin_chk(1'b1, 1'b1, 1'b0);
        pin_chk(1'b0, 1'b0, 1'b1);
        wr(7'h6B, 8'h00);
        wr(7'h6C, 8'h01);
        pin_chk(1'b0, 1'b1, 1'b0);
        // Frame sent while frozen must leave no trace
        clk_en = 1'b0;
        wr(7'h6C, 8'h00);
        clk_en = 1'b1;
        repeat (3) @(negedge clk_sys);
        check(cal_trigger, 1'b1);
        rd_chk(7'h6C, 8'h01);
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        check(low_power_cfg, 8'h88);
        tally_and_finish();
    end
endmodule : calibration_control_status_test
bind calibration_control_status cal_ctrl_monitor cal_ctrl_monitor_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_sdo_oe(spi_sdo_oe),
    .trigger_input_pin(trigger_input_pin), .status_output_pin(status_output_pin),
    .offset_average_depth(offset_average_depth), .foreground_run_enable(foreground_run_enable),
    .background_run_enable(background_run_enable), .low_power_cfg(low_power_cfg),
    .cal_trigger(cal_trigger), .core_wake(core_wake));
`default_nettype wire
